// [bench/sar_adc_sequencer_tb_top.sv]
`timescale 1ns/1ps
module sar_adc_sequencer_tb_top;
  import sas_pkg::*;
  logic              mclk_i;
  logic              rst_n_i;
  logic              stop;
  logic              cmp;
  sas_apb_req_type   req;
  sas_apb_rsp_type   rsp;
  sas_port_type      port;
  logic [3:0]        pin_in;
  logic [3:0]        pin_out;
  logic [3:0]        oe_n;
  logic [3:0]        prd;
  logic [4:0]        asel;
  logic              pdn;
  logic              smp;
  logic              irq;
  logic [7:0]        dac;
  logic signed [9:0] level;
  logic [31:0]       rd;
  logic              err;
  int                miscompares;
  int                total_checks;
  int                cyc;
  int                n;

  // Bus clock, 4 ns period
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  sas_top dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .apb_i(req), .apb_o(rsp), .port_i(port),
    .pin_i(pin_in), .pin_o(pin_out), .pin_oe_n_o(oe_n), .port_read_o(prd),
    .stop_mode_i(stop), .cmp_above_i(cmp), .analog_sel_o(asel), .power_down_o(pdn),
    .sample_o(smp), .dac_code_o(dac), .irq_o(irq)
  );

  sas_analog_model model (.level_i(level), .dac_code_i(dac), .cmp_above_o(cmp));

  task give_verdict;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // Hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task wt(input int c);
    repeat (c) @(posedge mclk_i);
  endtask : wt

  // One APB transfer, then one idle cycle
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    req.pstrb   <= 4'hF;
    @(posedge mclk_i);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge mclk_i);
  endtask : xfer

  task rdchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rdchk

  // Cycles until sample_o shows v, bounded
  task wait_smp(input logic v, input int lim);
    n = 0;
    while (smp !== v && n < lim) begin
      @(posedge mclk_i);
      n++;
    end
  endtask : wait_smp

  task conv(input logic signed [9:0] lv, input logic [7:0] e);
    level <= lv;
    xfer(1'b1, OFS_CTRL, 32'h01);
    wait_smp(1'b1, 4);
    check(n, 32'h1);
    wt(20);
    rdchk(OFS_CTRL, 32'h81);
    rdchk(OFS_RESULT, {24'h0, e});
    rdchk(OFS_CTRL, 32'h01);
  endtask : conv

  // Sample width and back-to-back period in continuous mode
  task per(input logic [2:0] code, input int dv);
    int w;
    xfer(1'b1, OFS_CLKDIV, {29'h0, code});
    xfer(1'b1, OFS_CTRL, 32'h21);
    wait_smp(1'b1, 40 * dv);
    wait_smp(1'b0, 20 * dv);
    wait_smp(1'b1, 20 * dv);
    wait_smp(1'b0, 20 * dv);
    // Sample ends on the eighth tick, seven periods after the start tick
    w = n;
    check(w, 7 * dv);
    wait_smp(1'b1, 20 * dv);
    check(w + n, 16 * dv);
  endtask : per

  function automatic logic [11:0] pexp(input int ch, input logic [3:0] lat, input logic [3:0] dd,
                                       input logic [3:0] pn);
    for (int i = 0; i < 4; i++) begin
      pexp[8+i] = (i == ch) ? 1'b1 : ~dd[i];
      pexp[4+i] = (i == ch) ? 1'b0 : lat[i];
      pexp[i]   = (i == ch) ? (dd[i] & lat[i]) : (dd[i] ? lat[i] : pn[i]);
    end
  endfunction : pexp

  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    stop = 1'b0;
    req = '0;
    port = '0;
    pin_in = 4'hA;
    level = '0;
    miscompares = 0;
    total_checks = 0;
    cyc = 0;
    wt(5);
    rst_n_i <= 1'b1;
    wt(2);
    check({pdn, oe_n, asel}, {1'b1, 4'hF, 5'h1F});
    rdchk(OFS_CTRL, 32'h1F);
    rdchk(OFS_CLKDIV, 32'h0);
    rdchk(OFS_IRQ_ENABLE, 32'h0);
    xfer(1'b0, 12'h0F0, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    // Single conversions, in range and saturated
    conv(10'sd90, 8'h5A);
    conv(10'sd300, 8'hFF);
    conv(-10'sd5, 8'h00);
    for (int i = 0; i < 5; i++) begin
      per(3'(i), 1 << i);
    end
    per(3'h7, 16);
    // Continuous overwrite, then single mode stays idle
    xfer(1'b1, OFS_CLKDIV, 32'h0);
    level <= 10'sd51;
    xfer(1'b1, OFS_CTRL, 32'h21);
    wt(40);
    level <= 10'sd119;
    wt(40);
    rdchk(OFS_RESULT, 32'h77);
    xfer(1'b1, OFS_CTRL, 32'h01);
    wt(20);
    wait_smp(1'b1, 60);
    check(n, 60);
    // Pin ownership for pin codes 0 to 3 and power-off, with two direction patterns
    for (int ch = 0; ch < 5; ch++) begin
      for (int k = 0; k < 2; k++) begin
        port.latch <= 4'h6;
        port.ddr <= k ? 4'hA : 4'h5;
        pin_in <= k ? 4'h9 : 4'h6;
        xfer(1'b1, OFS_CTRL, (ch == 4) ? 32'h1F : 32'(ch));
        wt(6);
        check({oe_n, pin_out, prd}, pexp(ch, 4'h6, port.ddr, pin_in));
        check({pdn, asel}, (ch == 4) ? 6'h3F : 6'(ch));
      end
    end
    // Interrupt raise, drop by read, drop by write, mask and clear
    level <= 10'sd16;
    xfer(1'b1, OFS_IRQ_ENABLE, 32'h1);
    xfer(1'b1, OFS_CTRL, 32'h41);
    wt(20);
    check(irq, 32'h1);
    rdchk(OFS_CTRL, 32'h41);
    rdchk(OFS_RESULT, 32'h10);
    check(irq, 32'h0);
    xfer(1'b1, OFS_CTRL, 32'h41);
    wt(20);
    check(irq, 32'h1);
    xfer(1'b1, OFS_CTRL, 32'h41);
    check(irq, 32'h0);
    wt(20);
    // Output follows the enable one cycle late
    xfer(1'b1, OFS_IRQ_ENABLE, 32'h0);
    wt(1);
    check(irq, 32'h0);
    rdchk(OFS_IRQ_STATUS, 32'h1);
    xfer(1'b1, OFS_IRQ_CLEAR, 32'h1);
    rdchk(OFS_IRQ_STATUS, 32'h0);
    // Stop aborts and resumes
    level <= 10'sd68;
    xfer(1'b1, OFS_CTRL, 32'h01);
    wt(5);
    stop <= 1'b1;
    wt(40);
    rdchk(OFS_CTRL, 32'h01);
    stop <= 1'b0;
    wt(25);
    rdchk(OFS_CTRL, 32'h81);
    rdchk(OFS_RESULT, 32'h44);
    // Powered off ahead of a wait: nothing converts
    xfer(1'b1, OFS_CTRL, 32'h1F);
    wait_smp(1'b1, 40);
    check(n, 40);
    check(pdn, 32'h1);
    give_verdict();
  end
endmodule : sar_adc_sequencer_tb_top

// [bench/sas_analog_model.sv]
`timescale 1ns/1ps
module sas_analog_model
(
  // Analog level and trial code
  input  wire logic signed [9:0] level_i,
  input  wire logic [7:0]        dac_code_i,
  // Comparator decision
  output logic                   cmp_above_o
);
  // Trial bit kept while input reaches it; out-of-range input saturates
  assign cmp_above_o = level_i >= $signed({2'h0, dac_code_i});
endmodule : sas_analog_model

// [inc/sas_pkg.sv]
package sas_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL       = 12'h03C;
  localparam logic [11:0] OFS_RESULT     = 12'h040;
  localparam logic [11:0] OFS_CLKDIV     = 12'h044;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h048;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h04C;
  localparam logic [11:0] OFS_IRQ_CLEAR  = 12'h050;

  // Control field positions
  localparam int CTRL_DONE_BIT  = 7;
  localparam int CTRL_IRQEN_BIT = 6;
  localparam int CTRL_CONT_BIT  = 5;

  // Select codes and reset values
  localparam logic [4:0] CH_POWER_OFF = 5'h1F;
  localparam logic [4:0] CH_VDD_REF   = 5'h1D;
  localparam logic [4:0] CH_VSS_REF   = 5'h1E;
  localparam logic [2:0] DIV_RESET    = 3'h0;
  localparam logic       IRQ_EN_RESET = 1'b0;

  // Conversion timing in converter clocks, and first trial code
  localparam logic [3:0] CONV_LAST   = 4'hF;
  localparam logic [3:0] SAMPLE_LAST = 4'h7;
  localparam logic [7:0] SAR_FIRST   = 8'h80;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ARMED = 2'h1,
    ST_CONV  = 2'h3
  } sas_state_type;

  typedef enum logic [2:0] {
    R_CTRL, R_RESULT, R_CLKDIV, R_IRQ_ST, R_IRQ_EN, R_IRQ_CLR, R_NONE
  } sas_reg_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } sas_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sas_apb_rsp_type;

  typedef struct packed {
    logic [3:0] latch;
    logic [3:0] ddr;
  } sas_port_type;
endpackage : sas_pkg

// [rtl/sas_top.sv]
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module sas_top
  import sas_pkg::*;
(
  // Clock and reset
  input  wire logic            mclk_i,
  input  wire logic            rst_n_i,
  // APB slave
  input  wire sas_apb_req_type apb_i,
  output sas_apb_rsp_type      apb_o,
  // Port logic and pins
  input  wire sas_port_type    port_i,
  input  wire logic [3:0]      pin_i,
  output logic [3:0]           pin_o,
  output logic [3:0]           pin_oe_n_o,
  output logic [3:0]           port_read_o,
  // Low-power mode
  input  wire logic            stop_mode_i,
  // Analog core
  input  wire logic            cmp_above_i,
  output logic [4:0]           analog_sel_o,
  output logic                 power_down_o,
  output logic                 sample_o,
  output logic [7:0]           dac_code_o,
  // Interrupt
  output logic                 irq_o
);

  sas_state_type state;
  sas_reg_type   sel;
  logic [3:0]    cnt;
  logic [3:0]    pre_cnt;
  logic [3:0]    div_last;
  logic [2:0]    div;
  logic [4:0]    ch;
  logic          cont;
  logic          conversion_irq_enable;
  logic          done_flag;
  logic          irq_st;
  logic          irq_en;
  logic [7:0]    sar;
  logic [7:0]    next_sar;
  logic [7:0]    result;
  logic [31:0]   next_rdata;
  logic [3:0]    own;
  logic [3:0]    s1;
  logic [3:0]    s2;
  logic [3:0]    s3;
  logic [3:0]    pin_stable;
  logic          setup;
  logic          acc;
  logic          wr;
  logic          wr_ctrl;
  logic          rd_result;
  logic          tick;
  logic          start;
  logic          done;
  logic          irq_clr;
  logic          next_irq_st;
  logic [2:0]    bit_idx;

  // Address decode shared by read mux and write strobes
  function automatic sas_reg_type reg_idx(input logic [11:0] a);
    unique case (a)
      OFS_CTRL:       return R_CTRL;
      OFS_RESULT:     return R_RESULT;
      OFS_CLKDIV:     return R_CLKDIV;
      OFS_IRQ_STATUS: return R_IRQ_ST;
      OFS_IRQ_ENABLE: return R_IRQ_EN;
      OFS_IRQ_CLEAR:  return R_IRQ_CLR;
      default:        return R_NONE;
    endcase
  endfunction : reg_idx

  // Bus phase strobes; a write needs the low byte lane
  assign sel       = reg_idx(apb_i.paddr);
  assign setup     = apb_i.psel & ~apb_i.penable;
  assign acc       = apb_i.psel & apb_i.penable & apb_o.pready;
  assign wr        = acc & apb_i.pwrite & apb_i.pstrb[0];
  assign wr_ctrl   = wr & (sel == R_CTRL);
  assign rd_result = acc & ~apb_i.pwrite & (sel == R_RESULT);

  // Read data mux
  always_comb begin
    unique case (sel)
      R_CTRL:   next_rdata = {24'h000000, done_flag, conversion_irq_enable, cont, ch};
      R_RESULT: next_rdata = {24'h000000, result};
      R_CLKDIV: next_rdata = {29'h00000000, div};
      R_IRQ_ST: next_rdata = {31'h00000000, irq_st};
      R_IRQ_EN: next_rdata = {31'h00000000, irq_en};
      default:  next_rdata = 32'h00000000;
    endcase
  end

  // One wait-free access phase; answer registered in the setup cycle
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      apb_o <= '0;
    end else begin
      apb_o.pready  <= setup;
      apb_o.pslverr <= setup & (sel == R_NONE);
      apb_o.prdata  <= (setup & ~apb_i.pwrite) ? next_rdata : 32'h00000000;
    end
  end

  // Control fields; reset leaves the converter powered off
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cont         <= 1'b0;
      conversion_irq_enable         <= 1'b0;
      ch           <= CH_POWER_OFF;
      power_down_o <= 1'b1;
    end else if (wr_ctrl) begin
      cont         <= apb_i.pwdata[CTRL_CONT_BIT];
      conversion_irq_enable         <= apb_i.pwdata[CTRL_IRQEN_BIT];
      ch           <= apb_i.pwdata[4:0];
      power_down_o <= apb_i.pwdata[4:0] == CH_POWER_OFF;
    end
  end

  assign analog_sel_o = ch;

  // Clock divider and interrupt enable registers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      div    <= DIV_RESET;
      irq_en <= IRQ_EN_RESET;
    end else begin
      if (wr & (sel == R_CLKDIV)) begin
        div <= apb_i.pwdata[2:0];
      end
      if (wr & (sel == R_IRQ_EN)) begin
        irq_en <= apb_i.pwdata[0];
      end
    end
  end

  // Converter clock as a one-cycle tick; top bit forces divide by 16
  assign div_last = div[2] ? 4'hF : 4'((4'h1 << div[1:0]) - 4'h1);
  assign tick     = ~stop_mode_i & (pre_cnt >= div_last);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || stop_mode_i || tick) begin
      pre_cnt <= 4'h0;
    end else begin
      pre_cnt <= 4'(pre_cnt + 4'h1);
    end
  end

  assign start = (state == ST_ARMED) & tick;
  assign done  = (state == ST_CONV) & tick & (cnt == CONV_LAST);

  // Sequencer: armed by a write, runs sixteen ticks per conversion
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      cnt   <= 4'h0;
    end else if (wr_ctrl) begin
      // Any control write aborts and re-arms unless powering off
      state <= (apb_i.pwdata[4:0] == CH_POWER_OFF) ? ST_IDLE : ST_ARMED;
      cnt   <= 4'h0;
    end else if (stop_mode_i && state == ST_CONV) begin
      state <= ST_ARMED;
      cnt   <= 4'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          cnt <= 4'h0;
        end
        ST_ARMED: begin
          if (tick) begin
            state <= ST_CONV;
            cnt   <= 4'h1;
          end
        end
        ST_CONV: begin
          if (tick) begin
            cnt <= 4'(cnt + 4'h1);
            if (cnt == CONV_LAST) begin
              state <= cont ? ST_ARMED : ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Successive approximation: decisions on the last eight ticks
  assign bit_idx = 3'(CONV_LAST - cnt);

  always_comb begin
    next_sar          = sar;
    next_sar[bit_idx] = cmp_above_i;
    if (bit_idx != 3'h0) begin
      next_sar[3'(bit_idx - 3'h1)] = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sar <= 8'h00;
    end else if (start) begin
      sar <= SAR_FIRST;
    end else if (state == ST_CONV && tick && cnt > SAMPLE_LAST) begin
      sar <= next_sar;
    end
  end

  assign dac_code_o = sar;

  // Result register, overwritten by every completed conversion
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      result <= 8'h00;
    end else if (done) begin
      result <= next_sar;
    end
  end

  // Sampling window covers the first eight converter clocks
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || wr_ctrl || stop_mode_i) begin
      sample_o <= 1'b0;
    end else if (start) begin
      sample_o <= 1'b1;
    end else if (state == ST_CONV && tick && cnt == SAMPLE_LAST) begin
      sample_o <= 1'b0;
    end
  end

  // Done flag only in polled mode; completion beats the clearing read
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      done_flag <= 1'b0;
    end else begin
      done_flag <= (done & ~conversion_irq_enable) | (done_flag & ~rd_result & ~conversion_irq_enable);
    end
  end

  // Interrupt status; set wins over every clear source
  assign irq_clr     = rd_result | wr_ctrl | (wr & (sel == R_IRQ_CLR) & apb_i.pwdata[0]);
  assign next_irq_st = (done & conversion_irq_enable) | (irq_st & ~irq_clr);

  // Level output stays live in wait so it can wake the core
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      irq_st <= 1'b0;
      irq_o  <= 1'b0;
    end else begin
      irq_st <= next_irq_st;
      irq_o  <= next_irq_st & irq_en;
    end
  end

  // Pin owned by the converter, only for pin codes 0 to 3
  assign own = (ch[4:2] == 3'h0) ? 4'(4'h1 << ch[1:0]) : 4'h0;

  // Pin input synchroniser; a level counts when stages two and three agree
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s1         <= 4'h0;
      s2         <= 4'h0;
      s3         <= 4'h0;
      pin_stable <= 4'h0;
    end else begin
      s1         <= pin_i;
      s2         <= s1;
      s3         <= s2;
      pin_stable <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & pin_stable);
    end
  end

  // Per-pin override of the port logic
  for (genvar i = 0; i < 4; i++) begin : g_pin
    always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
        pin_o[i]       <= 1'b0;
        pin_oe_n_o[i]  <= 1'b1;
        port_read_o[i] <= 1'b0;
      end else if (own[i]) begin
        pin_o[i]       <= 1'b0;
        pin_oe_n_o[i]  <= 1'b1;
        port_read_o[i] <= port_i.ddr[i] & port_i.latch[i];
      end else begin
        pin_o[i]       <= port_i.latch[i];
        pin_oe_n_o[i]  <= ~port_i.ddr[i];
        port_read_o[i] <= port_i.ddr[i] ? port_i.latch[i] : pin_stable[i];
      end
    end
  end

  // Checker helper: converter ticks since the start tick
  logic [3:0] ticks_seen;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || start) begin
      ticks_seen <= 4'h1;
    end else if (state == ST_CONV && tick) begin
      ticks_seen <= 4'(ticks_seen + 4'h1);
    end
  end

  sequence start_s;
    state == ST_ARMED && tick && !wr_ctrl;
  endsequence

  sequence done_s;
    done && !wr_ctrl && !stop_mode_i;
  endsequence

  conv_length_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    done |-> ticks_seen == 4'hF) else $error("conversion not sixteen ticks");

  start_tick_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    start_s |=> state == ST_CONV && sample_o && sar == SAR_FIRST) else $error("start missed tick");

  cont_rearm_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    done_s ##0 cont |=> state == ST_ARMED) else $error("continuous mode stopped");

  result_load_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    done |=> result == $past(next_sar)) else $error("result not loaded");

  flag_hold_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    done && !conversion_irq_enable |=> done_flag ##1 (done_flag || $past(rd_result) || $past(conversion_irq_enable)))
    else $error("done flag lost");

  flag_zero_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    conversion_irq_enable ##1 conversion_irq_enable |-> !done_flag) else $error("done flag set in interrupt mode");

  pin_owned_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    1'b1 |=> &(~$past(own) | pin_oe_n_o)) else $error("owned pin driven");

  pin_free_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    1'b1 |=> pin_oe_n_o == ($past(own) | ~$past(port_i.ddr))) else $error("free pin not ported");

  irq_drop_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    irq_clr && !done |=> !irq_st && !irq_o) else $error("interrupt not dropped");

  stop_abort_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    stop_mode_i && state == ST_CONV && !wr_ctrl |=> state == ST_ARMED && !sample_o)
    else $error("stop did not abort");

  single_idle_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    done_s ##0 !cont |=> state == ST_IDLE) else $error("single mode kept running");

endmodule : sas_top
